// ==== core/fpm_regs.vh ====
// Register offsets, field positions, limits and timing for the front-panel menu controller
`ifndef FPM_REGS_VH
`define FPM_REGS_VH

// ============================================================
// APB register byte offsets
`define FPM_A_CTRL 8'h00
`define FPM_A_STATUS 8'h04
`define FPM_A_FREQ 8'h08
`define FPM_A_LVLGAIN 8'h0C
`define FPM_A_FLAGS 8'h10
`define FPM_A_VERSION 8'h14

// ============================================================
// Control register: fitted options
`define FPM_CTRL_OPT_E 0
`define FPM_CTRL_OPT_Q 1
`define FPM_CTRL_OPT_T 2
`define FPM_CTRL_OPT_V 3
`define FPM_CTRL_RST 4'h0

// ============================================================
// Setting flag positions (active and stored)
`define FPM_FLAG_MUTE 0
`define FPM_FLAG_REMOTE 1
`define FPM_FLAG_EXTREF 2
`define FPM_FLAG_REFOUT 3
`define FPM_FLAG_RMODE 4

// ============================================================
// Timing: clock rate and times in their own units
`define FPM_CLK_KHZ 25000
`define FPM_TIMEOUT_MS 12000
`define FPM_STAGE_MS 1000
`define FPM_DEBOUNCE_MS 10
`define FPM_FMUTE_MS 20

// ============================================================
// Setting limits in MHz, dBm and dB
`define FPM_FREQ_MIN 900
`define FPM_FREQ_MAX 1450
`define FPM_LEVEL_MIN (-40)
`define FPM_LEVEL_MAX (-10)
`define FPM_GAIN_MIN (-10)
`define FPM_GAIN_MAX 30
`define FPM_OUT_MIN (-20)
`define FPM_OUT_MAX 0

// ============================================================
// Defaults used when the non-volatile copy is blank
`define FPM_DEF_LEVEL 7'h6C
`define FPM_DEF_GAIN 10'h000
`define FPM_DEF_FLAGS 5'h01
`define FPM_DEF_ADDR 5'h00

`endif

// ==== core/fpm_ctrl.v ====
// Front-panel menu controller: switches, menu walk, edit session, settings and APB slave
//
// Behaviour
// - 12 s idle in session reverts edits
// - Session starts and ends with menu/execute press
// - Power-up: segment test, version, status, run
// - Saved settings reloaded from non-volatile store
// - Horizontal rocker moves cursor one digit
// - Vertical rocker steps digit at cursor
// - Vertical rocker toggles on/off settings
// - Frequency applied only after save confirmed
// - Carrier muted while new frequency applied
// - Save yes commits, no reverts everything
// - Level and gain edits applied immediately
// - Level menu steps by 1 dB
// - Gain steps 1 or 10 dB by cursor
// - Gain limited to -10..+30 dB
// - Input level limited to -40..-10 dBm
// - Reject level plus gain outside -20..0 dBm
// - Alarm on PLL loss of lock lasting two clocks
// - Mute and remote LEDs follow selections
// - Fixed menu order, absent options skipped, save last
// - Press advances; press at return goes to save
// - Frequency 900..1450 MHz, optional finer resolution
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "fpm_regs.vh"

module fpm_ctrl #(
    parameter FREQ_SCALE = 1,
    parameter FDIG = 4,
    parameter GAIN_SCALE = 1,
    parameter GDIG = 2,
    parameter [15:0] VERSION = 16'h0100,
    parameter TIMEOUT_CYC = `FPM_TIMEOUT_MS * `FPM_CLK_KHZ,
    parameter STAGE_CYC = `FPM_STAGE_MS * `FPM_CLK_KHZ,
    parameter DEB_CYC = `FPM_DEBOUNCE_MS * `FPM_CLK_KHZ,
    parameter FMUTE_CYC = `FPM_FMUTE_MS * `FPM_CLK_KHZ
) (
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sw_menu_n,
    input wire sw_left_n,
    input wire sw_right_n,
    input wire sw_up_n,
    input wire sw_down_n,
    input wire pll_unlock,
    input wire nv_valid,
    input wire [20:0] nv_rd_freq,
    input wire [6:0] nv_rd_level,
    input wire [9:0] nv_rd_gain,
    input wire [4:0] nv_rd_flags,
    input wire [4:0] nv_rd_addr,
    output reg nv_wr_stb_q,
    output reg [20:0] nv_wr_freq_q,
    output reg [6:0] nv_wr_level_q,
    output reg [9:0] nv_wr_gain_q,
    output reg [4:0] nv_wr_flags_q,
    output reg [4:0] nv_wr_addr_q,
    output reg [2:0] disp_stage_q,
    output reg [3:0] menu_q,
    output reg [2:0] cursor_q,
    output reg save_yes_q,
    output reg [20:0] edit_freq_q,
    output reg [20:0] freq_q,
    output reg [6:0] level_q,
    output reg [9:0] gain_q,
    output reg [4:0] flags_q,
    output reg [4:0] addr_q,
    output reg carrier_mute_q,
    output reg led_alarm_q,
    output reg led_mute_q,
    output reg led_remote_q
);

    // ============================================================
    // Local codes
    localparam [2:0] ST_TEST = 3'h0;
    localparam [2:0] ST_VER = 3'h1;
    localparam [2:0] ST_SHOW = 3'h2;
    localparam [2:0] ST_NORM = 3'h3;
    localparam [2:0] ST_MENU = 3'h4;
    localparam [2:0] ST_SAVE = 3'h5;

    localparam [3:0] M_NORMAL = 4'h0;
    localparam [3:0] M_FREQ = 4'h1;
    localparam [3:0] M_LEVEL = 4'h2;
    localparam [3:0] M_GAIN = 4'h3;
    localparam [3:0] M_MUTE = 4'h4;
    localparam [3:0] M_REMOTE = 4'h5;
    localparam [3:0] M_EXTREF = 4'h6;
    localparam [3:0] M_REFOUT = 4'h7;
    localparam [3:0] M_RMODE = 4'h8;
    localparam [3:0] M_ADDR = 4'h9;
    localparam [3:0] M_TEMP = 4'hA;
    localparam [3:0] M_CURR = 4'hB;
    localparam [3:0] M_SAVE = 4'hC;

    localparam [2:0] FDIG_W = FDIG[2:0];
    localparam [2:0] GDIG_W = GDIG[2:0];
    localparam integer FMIN = `FPM_FREQ_MIN * FREQ_SCALE;
    localparam integer FMAX = `FPM_FREQ_MAX * FREQ_SCALE;
    localparam integer GMIN = `FPM_GAIN_MIN * GAIN_SCALE;
    localparam integer GMAX = `FPM_GAIN_MAX * GAIN_SCALE;
    localparam integer OMIN = `FPM_OUT_MIN * GAIN_SCALE;
    localparam integer OMAX = `FPM_OUT_MAX * GAIN_SCALE;
    localparam [31:0] FMUTE_HALF = FMUTE_CYC / 2;

    reg [3:0] opt_q;
    reg [2:0] st_q;
    reg [31:0] tm_q;
    reg [31:0] fm_cnt_q;
    reg [2:0] pll_sy_q;
    wire [4:0] sw_raw;
    wire [4:0] ev;

    // ============================================================
    // Menu helpers
    function fpm_avail;
        input [3:0] m;
        input [3:0] o;
        begin
            case (m)
                M_EXTREF, M_REFOUT: fpm_avail = o[`FPM_CTRL_OPT_E];
                M_RMODE, M_ADDR: fpm_avail = o[`FPM_CTRL_OPT_Q];
                M_TEMP: fpm_avail = o[`FPM_CTRL_OPT_T];
                M_CURR: fpm_avail = o[`FPM_CTRL_OPT_V];
                default: fpm_avail = 1'b1;
            endcase
        end
    endfunction

    function [3:0] fpm_next;
        input [3:0] m;
        input [3:0] o;
        reg [3:0] n;
        integer i;
        begin
            n = m + 4'h1;
            for (i = 0; i < 6; i = i + 1)
            begin
                if (!fpm_avail(n, o))
                    n = n + 4'h1;
            end
            fpm_next = n;
        end
    endfunction

    // Digit count of the edited value; the position above the top digit is the return mark
    function [2:0] fpm_ndig;
        input [3:0] m;
        begin
            case (m)
                M_FREQ: fpm_ndig = FDIG_W;
                M_GAIN: fpm_ndig = GDIG_W;
                default: fpm_ndig = 3'h1;
            endcase
        end
    endfunction

    function [31:0] fpm_pow10;
        input [2:0] c;
        begin
            case (c)
                3'h0: fpm_pow10 = 32'h0000_0001;
                3'h1: fpm_pow10 = 32'h0000_000A;
                3'h2: fpm_pow10 = 32'h0000_0064;
                3'h3: fpm_pow10 = 32'h0000_03E8;
                3'h4: fpm_pow10 = 32'h0000_2710;
                3'h5: fpm_pow10 = 32'h0001_86A0;
                3'h6: fpm_pow10 = 32'h000F_4240;
                default: fpm_pow10 = 32'h0000_0000;
            endcase
        end
    endfunction

    // ============================================================
    // Switch synchronisers and debouncers
    assign sw_raw = {~sw_down_n, ~sw_up_n, ~sw_right_n, ~sw_left_n, ~sw_menu_n};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sw
            reg [2:0] sy_q;
            reg stab_q;
            reg ev_q;
            reg [31:0] cnt_q;
            assign ev[gi] = ev_q;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sy_q <= 3'h0;
                    stab_q <= 1'b0;
                    ev_q <= 1'b0;
                    cnt_q <= 32'h0;
                end
                else
                begin
                    sy_q <= {sy_q[1:0], sw_raw[gi]};
                    ev_q <= 1'b0;
                    // Level must hold steady for the whole window before it counts
                    if (sy_q[1] != sy_q[2] || sy_q[2] == stab_q)
                        cnt_q <= 32'h0;
                    else if (cnt_q == DEB_CYC - 1)
                    begin
                        cnt_q <= 32'h0;
                        stab_q <= sy_q[2];
                        ev_q <= sy_q[2];
                    end
                    else
                        cnt_q <= cnt_q + 32'h1;
                end
            end
        end
    endgenerate

    wire ev_menu = ev[0];
    wire ev_left = ev[1];
    wire ev_right = ev[2];
    wire ev_up = ev[3];
    wire ev_vert = ev[3] | ev[4];
    wire any_ev = |ev;

    // ============================================================
    // Session control signals
    wire [2:0] ndig_w = fpm_ndig(menu_q);
    wire sess_w = (st_q == ST_MENU) || (st_q == ST_SAVE);
    wire tmo_w = sess_w && !any_ev && (tm_q >= TIMEOUT_CYC - 1);
    wire start_w = (st_q == ST_NORM) && ev_menu;
    wire commit_w = (st_q == ST_SAVE) && ev_menu && save_yes_q;
    wire revert_w = tmo_w || ((st_q == ST_SAVE) && ev_menu && !save_yes_q);
    wire load_w = (st_q == ST_TEST) && (tm_q == STAGE_CYC - 1);
    wire edit_w = (st_q == ST_MENU) && ev_vert;
    wire fchg_w = commit_w && (edit_freq_q != freq_q);

    // ============================================================
    // Display sequence and menu walk
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= ST_TEST;
            tm_q <= 32'h0;
            menu_q <= M_NORMAL;
            cursor_q <= 3'h0;
            save_yes_q <= 1'b0;
            disp_stage_q <= ST_TEST;
        end
        else
        begin
            disp_stage_q <= st_q;
            case (st_q)
                ST_TEST, ST_VER, ST_SHOW:
                begin
                    if (tm_q == STAGE_CYC - 1)
                    begin
                        tm_q <= 32'h0;
                        st_q <= st_q + 3'h1;
                    end
                    else
                        tm_q <= tm_q + 32'h1;
                end
                ST_NORM:
                begin
                    tm_q <= 32'h0;
                    if (start_w)
                    begin
                        st_q <= ST_MENU;
                        menu_q <= M_FREQ;
                        cursor_q <= 3'h0;
                        save_yes_q <= 1'b0;
                    end
                end
                ST_MENU:
                begin
                    tm_q <= any_ev ? 32'h0 : tm_q + 32'h1;
                    if (tmo_w)
                    begin
                        st_q <= ST_NORM;
                        menu_q <= M_NORMAL;
                    end
                    else if (ev_menu)
                    begin
                        cursor_q <= 3'h0;
                        if (cursor_q == ndig_w || fpm_next(menu_q, opt_q) == M_SAVE)
                        begin
                            st_q <= ST_SAVE;
                            menu_q <= M_SAVE;
                        end
                        else
                            menu_q <= fpm_next(menu_q, opt_q);
                    end
                    else if (ev_left && cursor_q < ndig_w)
                        cursor_q <= cursor_q + 3'h1;
                    else if (ev_right && cursor_q != 3'h0)
                        cursor_q <= cursor_q - 3'h1;
                end
                ST_SAVE:
                begin
                    tm_q <= any_ev ? 32'h0 : tm_q + 32'h1;
                    if (tmo_w || ev_menu)
                    begin
                        st_q <= ST_NORM;
                        menu_q <= M_NORMAL;
                        cursor_q <= 3'h0;
                    end
                    else if (ev_vert)
                        save_yes_q <= ~save_yes_q;
                end
                default:
                begin
                    st_q <= ST_TEST;
                    tm_q <= 32'h0;
                end
            endcase
        end
    end

    // ============================================================
    // Candidate values for the digit under the cursor
    reg signed [31:0] dlt;
    reg signed [31:0] f_c;
    reg signed [31:0] l_c;
    reg signed [31:0] g_c;
    reg f_ok;
    reg l_ok;
    reg g_ok;
    wire signed [31:0] gs_w = $signed({{22{gain_q[9]}}, gain_q});
    wire signed [31:0] ls_w = $signed({{25{level_q[6]}}, level_q});

    always @*
    begin
        dlt = $signed(fpm_pow10(cursor_q));
        if (!ev_up)
            dlt = -dlt;
        f_c = $signed({11'h000, edit_freq_q}) + dlt;
        l_c = ls_w + (ev_up ? 32'sd1 : -32'sd1);
        g_c = gs_w + dlt;
        f_ok = (cursor_q < FDIG_W) && (f_c >= FMIN) && (f_c <= FMAX);
        l_ok = (l_c >= `FPM_LEVEL_MIN) && (l_c <= `FPM_LEVEL_MAX)
            && (l_c * GAIN_SCALE + gs_w >= OMIN)
            && (l_c * GAIN_SCALE + gs_w <= OMAX);
        g_ok = (cursor_q < GDIG_W) && (g_c >= GMIN) && (g_c <= GMAX)
            && (ls_w * GAIN_SCALE + g_c >= OMIN)
            && (ls_w * GAIN_SCALE + g_c <= OMAX);
    end

    // Blank store falls back to the bottom of the band
    wire [47:0] ld_w = nv_valid ? {nv_rd_freq, nv_rd_level, nv_rd_gain, nv_rd_flags, nv_rd_addr}
        : {FMIN[20:0], `FPM_DEF_LEVEL, `FPM_DEF_GAIN, `FPM_DEF_FLAGS, `FPM_DEF_ADDR};

    // ============================================================
    // Active, pending and stored settings
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nv_wr_stb_q <= 1'b0;
            nv_wr_freq_q <= 21'h0;
            nv_wr_level_q <= `FPM_DEF_LEVEL;
            nv_wr_gain_q <= `FPM_DEF_GAIN;
            nv_wr_flags_q <= `FPM_DEF_FLAGS;
            nv_wr_addr_q <= `FPM_DEF_ADDR;
            edit_freq_q <= 21'h0;
            freq_q <= 21'h0;
            level_q <= `FPM_DEF_LEVEL;
            gain_q <= `FPM_DEF_GAIN;
            flags_q <= `FPM_DEF_FLAGS;
            addr_q <= `FPM_DEF_ADDR;
            fm_cnt_q <= 32'h0;
            carrier_mute_q <= 1'b1;
            led_mute_q <= 1'b0;
            led_remote_q <= 1'b0;
        end
        else
        begin
            nv_wr_stb_q <= 1'b0;
            led_mute_q <= flags_q[`FPM_FLAG_MUTE];
            led_remote_q <= flags_q[`FPM_FLAG_REMOTE];
            // Carrier stays off for the whole retune window, not just the edge
            carrier_mute_q <= flags_q[`FPM_FLAG_MUTE] | (fm_cnt_q != 32'h0) | fchg_w;
            if (fm_cnt_q != 32'h0)
                fm_cnt_q <= fm_cnt_q - 32'h1;
            if (fm_cnt_q == FMUTE_HALF + 32'h1)
                freq_q <= nv_wr_freq_q;
            if (load_w)
            begin
                {nv_wr_freq_q, nv_wr_level_q, nv_wr_gain_q, nv_wr_flags_q, nv_wr_addr_q} <= ld_w;
                {edit_freq_q, level_q, gain_q, flags_q, addr_q} <= ld_w;
                fm_cnt_q <= FMUTE_CYC;
            end
            else if (commit_w)
            begin
                nv_wr_stb_q <= 1'b1;
                {nv_wr_freq_q, nv_wr_level_q, nv_wr_gain_q, nv_wr_flags_q, nv_wr_addr_q} <=
                    {edit_freq_q, level_q, gain_q, flags_q, addr_q};
                if (fchg_w)
                    fm_cnt_q <= FMUTE_CYC;
            end
            else if (revert_w)
            begin
                // Immediate edits are undone too, from the stored copy
                {edit_freq_q, level_q, gain_q, flags_q, addr_q} <=
                    {nv_wr_freq_q, nv_wr_level_q, nv_wr_gain_q, nv_wr_flags_q, nv_wr_addr_q};
            end
            else if (start_w)
                edit_freq_q <= nv_wr_freq_q;
            else if (edit_w)
            begin
                case (menu_q)
                    M_FREQ:
                        if (f_ok)
                            edit_freq_q <= f_c[20:0];
                    M_LEVEL:
                        if (l_ok)
                            level_q <= l_c[6:0];
                    M_GAIN:
                        if (g_ok)
                            gain_q <= g_c[9:0];
                    M_MUTE:
                        flags_q[`FPM_FLAG_MUTE] <= ~flags_q[`FPM_FLAG_MUTE];
                    M_REMOTE:
                        flags_q[`FPM_FLAG_REMOTE] <= ~flags_q[`FPM_FLAG_REMOTE];
                    M_EXTREF:
                        flags_q[`FPM_FLAG_EXTREF] <= ~flags_q[`FPM_FLAG_EXTREF];
                    M_REFOUT:
                        flags_q[`FPM_FLAG_REFOUT] <= ~flags_q[`FPM_FLAG_REFOUT];
                    M_RMODE:
                        flags_q[`FPM_FLAG_RMODE] <= ~flags_q[`FPM_FLAG_RMODE];
                    M_ADDR:
                        addr_q <= ev_up ? addr_q + 5'h01 : addr_q - 5'h01;
                    default:
                        addr_q <= addr_q;
                endcase
            end
        end
    end

    // ============================================================
    // Lock alarm
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pll_sy_q <= 3'h0;
            led_alarm_q <= 1'b0;
        end
        else
        begin
            pll_sy_q <= {pll_sy_q[1:0], pll_unlock};
            if (pll_sy_q[1] == pll_sy_q[2])
                led_alarm_q <= pll_sy_q[2];
        end
    end

    // ============================================================
    // APB slave: one access cycle, read data captured in the setup cycle
    reg [31:0] rd_w;
    reg hit_w;

    always @*
    begin
        hit_w = 1'b1;
        case (paddr)
            `FPM_A_CTRL: rd_w = {28'h0000000, opt_q};
            `FPM_A_STATUS: rd_w = {19'h00000, led_alarm_q, carrier_mute_q, save_yes_q,
                cursor_q, menu_q, st_q};
            `FPM_A_FREQ: rd_w = {11'h000, freq_q};
            `FPM_A_LVLGAIN: rd_w = {6'h00, gain_q, 9'h000, level_q};
            `FPM_A_FLAGS: rd_w = {22'h000000, addr_q, flags_q};
            `FPM_A_VERSION: rd_w = {16'h0000, VERSION};
            default:
            begin
                rd_w = 32'h0000_0000;
                hit_w = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            opt_q <= `FPM_CTRL_RST;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_w;
            if (psel && !penable)
                prdata <= pwrite ? 32'h0000_0000 : rd_w;
            // Option mask steers which menus are walked
            if (psel && penable && pready && pwrite && paddr == `FPM_A_CTRL)
                opt_q <= pwdata[3:0];
        end
    end

endmodule

// ==== testbench/fpm_properties.sv ====
// Port-level checker for the front-panel menu controller
`timescale 1ns/100ps
module fpm_properties (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pll_unlock,
    input wire nv_wr_stb_q,
    input wire [20:0] nv_wr_freq_q,
    input wire [2:0] disp_stage_q,
    input wire [3:0] menu_q,
    input wire save_yes_q,
    input wire [20:0] freq_q,
    input wire [6:0] level_q,
    input wire [9:0] gain_q,
    input wire [4:0] flags_q,
    input wire carrier_mute_q,
    input wire led_alarm_q,
    input wire led_mute_q,
    input wire led_remote_q
);
    // ============================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // Bound of 12 assumes the retune window is set to 8 cycles in the bench
    sequence s_commit;
        nv_wr_stb_q && nv_wr_freq_q != freq_q;
    endsequence
    a_apb_ready: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_gain_range: assert property ($signed(gain_q) >= -10 && $signed(gain_q) <= 30)
        else $error("gain out of range");
    a_level_range: assert property ($signed(level_q) >= -40 && $signed(level_q) <= -10)
        else $error("level out of range");
    a_output_window: assert property ($signed(level_q) + $signed(gain_q) >= -20 &&
        $signed(level_q) + $signed(gain_q) <= 0) else $error("output level out of window");
    a_freq_range: assert property (disp_stage_q >= 3 |-> freq_q >= 900 && freq_q <= 1450)
        else $error("frequency out of range");
    a_alarm_set: assert property (pll_unlock [*6] |-> led_alarm_q)
        else $error("alarm not raised");
    a_alarm_clear: assert property (!pll_unlock [*6] |-> !led_alarm_q)
        else $error("alarm stuck");
    a_led_follow: assert property (disp_stage_q >= 3 && $stable(flags_q) [*3] |->
        led_mute_q == flags_q[0] && led_remote_q == flags_q[1]) else $error("led mismatch");
    a_freq_commit: assert property (s_commit |-> ##[1:12] (freq_q == nv_wr_freq_q &&
        carrier_mute_q)) else $error("committed frequency not applied under mute");
    a_retune_mute: assert property (disp_stage_q >= 3 && $changed(freq_q) |-> carrier_mute_q)
        else $error("frequency changed unmuted");
    a_save_only: assert property (nv_wr_stb_q |-> $past(menu_q) == 4'hC && $past(save_yes_q))
        else $error("store written outside save yes");
    a_stage_step: assert property ($past(disp_stage_q) < 3 && disp_stage_q != $past(disp_stage_q)
        |-> disp_stage_q == $past(disp_stage_q) + 1) else $error("power-up stage skipped");
endmodule

bind fpm_ctrl fpm_properties chk_u (.*);

// ==== testbench/fpm_panel.sv ====
// Operator switches and non-volatile store model
`timescale 1ns/100ps
module fpm_panel (
    input wire pclk,
    input wire nv_wr_stb,
    input wire [47:0] nv_wr,
    output logic [4:0] sw_n,
    output logic nv_valid,
    output logic [47:0] nv_rd
);
    initial
    begin
        sw_n = 5'h1F;
        nv_valid = 1'b0;
        nv_rd = 48'h0;
    end
    // Store ignores reset, so a second reset shows reload from it
    always @(posedge pclk)
    begin
        if (nv_wr_stb)
        begin
            nv_rd <= nv_wr;
            nv_valid <= 1'b1;
        end
    end
    // Switch k: 0 menu, 1 left, 2 right, 3 up, 4 down; pins pulled up when released
    task press(input int k, input int len);
        sw_n[k] <= 1'b0;
        repeat (len) @(posedge pclk);
        sw_n[k] <= 1'b1;
        repeat (12) @(posedge pclk);
    endtask
endmodule

// ==== testbench/front_panel_menu_controller_tb.sv ====
// Self-checking bench for the front-panel menu controller
`timescale 1ns/100ps
`include "fpm_regs.vh"
module front_panel_menu_controller_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pll_unlock = 0, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, nv_valid, stb;
    wire [4:0] sw_n, wfl, wad;
    wire [47:0] nv_rd;
    wire [20:0] wfr, edit_freq_q;
    wire [6:0] wlv;
    wire [9:0] wga;
    wire [2:0] disp_stage_q;
    int fails = 0, n_checks = 0, cyc = 0;
    fpm_ctrl #(.TIMEOUT_CYC(200), .STAGE_CYC(20), .DEB_CYC(4), .FMUTE_CYC(8)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sw_menu_n(sw_n[0]), .sw_left_n(sw_n[1]), .sw_right_n(sw_n[2]), .sw_up_n(sw_n[3]),
        .sw_down_n(sw_n[4]), .pll_unlock(pll_unlock), .nv_valid(nv_valid),
        .nv_rd_freq(nv_rd[47:27]), .nv_rd_level(nv_rd[26:20]), .nv_rd_gain(nv_rd[19:10]),
        .nv_rd_flags(nv_rd[9:5]), .nv_rd_addr(nv_rd[4:0]), .nv_wr_stb_q(stb),
        .nv_wr_freq_q(wfr), .nv_wr_level_q(wlv), .nv_wr_gain_q(wga), .nv_wr_flags_q(wfl),
        .nv_wr_addr_q(wad), .disp_stage_q(disp_stage_q), .menu_q(), .cursor_q(),
        .save_yes_q(), .edit_freq_q(edit_freq_q), .freq_q(), .level_q(), .gain_q(),
        .flags_q(), .addr_q(), .carrier_mute_q(), .led_alarm_q(), .led_mute_q(),
        .led_remote_q());
    fpm_panel panel_u (.pclk(pclk), .nv_wr_stb(stb), .nv_wr({wfr, wlv, wga, wfl, wad}),
        .sw_n(sw_n), .nv_valid(nv_valid), .nv_rd(nv_rd));
    // ============================================================
    // Clock, timeout and tasks
    initial
    begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            final_report;
        end
    end
    task final_report;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits on pready with no fixed latency; a hang is cut by the cycle ceiling
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task st(input string nm, input logic [31:0] e);
        apb(0, `FPM_A_STATUS, 0);
        chk(nm, e, {28'h0, rd[6:3]});
    endtask
    task pr(input int k);
        panel_u.press(k, 10);
    endtask
    task boot(input logic [31:0] f);
        repeat (70) @(posedge pclk);
        chk("stage", 3, {29'h0, disp_stage_q});
        apb(0, `FPM_A_FREQ, 0);
        chk("freq", f, rd);
    endtask
    // ============================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        boot(900);
        apb(0, `FPM_A_VERSION, 0);
        chk("version", 32'h00000100, rd);
        apb(0, 8'h18, 0);
        chk("slverr", 1, {31'h0, err});
        apb(1, `FPM_A_CTRL, 32'h0000000F);
        apb(0, `FPM_A_CTRL, 0);
        chk("ctrl", 32'h0000000F, rd);
        panel_u.press(0, 2);
        st("menu glitch", 0);
        pr(0);
        st("menu start", 1);
        pr(2);
        pr(1);
        apb(0, `FPM_A_STATUS, 0);
        chk("cursor", 1, {29'h0, rd[9:7]});
        pr(3);
        chk("edit freq", 910, {11'h0, edit_freq_q});
        apb(0, `FPM_A_FREQ, 0);
        chk("freq held", 900, rd);
        pr(0);
        pr(3);
        apb(0, `FPM_A_LVLGAIN, 0);
        chk("level", 7'h6D, {25'h0, rd[6:0]});
        pr(0);
        pr(2);
        pr(2);
        pr(3);
        pr(1);
        pr(3);
        pr(3);
        apb(0, `FPM_A_LVLGAIN, 0);
        chk("gain", 10'h00B, {22'h0, rd[25:16]});
        pr(0);
        for (int i = 0; i < 3; i++)
        begin
            pr(i % 2 ? 3 : 4);
            apb(0, `FPM_A_FLAGS, 0);
            chk("mute", i % 2, {31'h0, rd[0]});
        end
        pr(0);
        pr(3);
        apb(0, `FPM_A_FLAGS, 0);
        chk("flags", 5'h02, {27'h0, rd[4:0]});
        for (int m = 6; m <= 12; m++)
        begin
            pr(0);
            st("menu walk", m);
        end
        pr(3);
        pr(0);
        apb(0, `FPM_A_FREQ, 0);
        chk("freq saved", 910, rd);
        st("menu after save", 0);
        pr(0);
        pr(0);
        pr(3);
        repeat (220) @(posedge pclk);
        apb(0, `FPM_A_LVLGAIN, 0);
        chk("level timeout", 7'h6D, {25'h0, rd[6:0]});
        pr(0);
        pr(3);
        for (int i = 0; i < 5; i++)
            pr(1);
        pr(0);
        st("menu jump", 12);
        pr(0);
        apb(0, `FPM_A_FREQ, 0);
        chk("freq reverted", 910, rd);
        pll_unlock <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(0, `FPM_A_STATUS, 0);
        chk("alarm", 1, {31'h0, rd[12]});
        pll_unlock <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        boot(910);
        apb(0, `FPM_A_LVLGAIN, 0);
        chk("reload", {10'h00B, 7'h6D}, {15'h0, rd[25:16], rd[6:0]});
        final_report;
    end
endmodule
